// ---- dv/eqc_host_model.sv ----
// host serial master and board straps around the equalizer control
`timescale 1ns/1ps
module eqc_host_model
(
    input wire logic clk,
    input wire logic carrier_present_n,
    input wire logic miso,
    input wire logic auto_mute,
    input wire logic manual_squelch,
    output logic squelch,
    output logic sck,
    output logic ss_n,
    output logic mosi
);
    // board strap: flag fed back to squelch mutes a dead input
    assign squelch = auto_mute ? carrier_present_n : manual_squelch;
    initial
    begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // nbits below 16 gives a cut frame; half sets the clock half period
    task automatic frame(input logic [15:0] tx, input int nbits,
        input int half, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        ss_n <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            mosi <= tx[i];
            repeat (half) @(posedge clk);
            rx = {rx[14:0], miso};
            sck <= 1'b1;
            repeat (half) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (half) @(posedge clk);
        ss_n <= 1'b1;
        mosi <= 1'b0;
        repeat (half) @(posedge clk);
    endtask
endmodule

// ---- dv/eqc_top_assertions.sv ----
// concurrent checks on the equalizer control top level ports
`timescale 1ns/1ps
module eqc_top_assertions
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic access_select,
    input wire logic second_output_off,
    input wire logic squelch,
    input wire logic bypass,
    input wire logic idle_powerdown,
    input wire logic energy_detect,
    input wire logic serial_data_in,
    input wire logic ss_n,
    input wire logic miso_oe,
    input wire logic carrier_present_n,
    input wire logic primary_serial_out,
    input wire logic primary_out_en,
    input wire logic secondary_out_en,
    input wire logic eq_filter_en,
    input wire logic dc_restore_en
);
    // ****************************************
    // pin mode and serial-mode miso drive; three steady samples cover the registered carrier flag
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_flag_no_energy: assert property
        (!energy_detect |=> carrier_present_n)
        else $error("flag low without energy");
    a_squelch_high: assert property
        (!access_select && squelch ##1 primary_out_en
        |-> primary_serial_out)
        else $error("output not forced high");
    a_data_passes: assert property
        (!access_select && !squelch ##1 primary_out_en
        |-> primary_serial_out == $past(serial_data_in))
        else $error("output does not carry data");
    a_second_float: assert property ((!access_select && second_output_off) [*3]
        |-> !secondary_out_en)
        else $error("second driver not floated");
    a_bypass_off: assert property ((!access_select && bypass) [*3]
        |-> !eq_filter_en && !dc_restore_en)
        else $error("filter active in bypass");
    a_eq_active: assert property
        ((!access_select && !bypass && !idle_powerdown) [*3]
        |-> eq_filter_en && dc_restore_en && primary_out_en)
        else $error("filter or driver idle");
    a_idle_floats: assert property
        ((!access_select && idle_powerdown && carrier_present_n) [*3]
        |-> !primary_out_en && !secondary_out_en)
        else $error("drivers on in power-down");
    a_pin_quiet: assert property (!access_select |-> !miso_oe)
        else $error("miso driven in pin mode");
    a_miso_drives: assert property (access_select && !ss_n |-> miso_oe)
        else $error("miso not driven in frame");
    c_squelch: cover property (squelch && primary_out_en);
    c_power_down: cover property (idle_powerdown && !primary_out_en);
    c_frame: cover property (access_select && miso_oe);
endmodule

bind eqc_top eqc_top_assertions u_eqc_top_assertions (.clk(clk),
    .rst_b(rst_b), .access_select(access_select),
    .second_output_off(second_output_off), .squelch(squelch),
    .bypass(bypass), .idle_powerdown(idle_powerdown),
    .energy_detect(energy_detect), .serial_data_in(serial_data_in),
    .ss_n(ss_n), .miso_oe(miso_oe), .carrier_present_n(carrier_present_n),
    .primary_serial_out(primary_serial_out),
    .primary_out_en(primary_out_en), .secondary_out_en(secondary_out_en),
    .eq_filter_en(eq_filter_en), .dc_restore_en(dc_restore_en));

// ---- dv/equalizer_control_logic_test.sv ----
// self-checking bench for the equalizer control logic
`timescale 1ns/1ps
`include "eqc_cfg.svh"
module equalizer_control_logic_test;
    localparam logic [11:0] thr_a = `EQC_OFS_CFG_BASE + 12'h00c;
    localparam logic [11:0] ist_a = `EQC_OFS_INT_STATUS;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
    logic access_select, second_output_off, bypass, idle_powerdown;
    logic energy_detect, analog_thr_trip, serial_data_in, sck, ss_n, mosi;
    logic miso, miso_oe, squelch, carrier_present_n, auto_mute, man_sq;
    logic primary_serial_out, secondary_serial_out, primary_out_en;
    logic secondary_out_en, eq_filter_en, dc_restore_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] signal_metric, thr;
    logic [15:0] rx;
    logic [31:0] exp_q[$];
    int n_fail, n_checks, cycles;

    eqc_top u_eqc_top (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .access_select(access_select), .squelch(squelch), .bypass(bypass),
        .second_output_off(second_output_off), .sck(sck), .ss_n(ss_n),
        .idle_powerdown(idle_powerdown), .energy_detect(energy_detect),
        .analog_thr_trip(analog_thr_trip), .signal_metric(signal_metric),
        .serial_data_in(serial_data_in), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .carrier_present_n(carrier_present_n),
        .primary_serial_out(primary_serial_out),
        .secondary_serial_out(secondary_serial_out),
        .primary_out_en(primary_out_en), .secondary_out_en(secondary_out_en),
        .eq_filter_en(eq_filter_en), .dc_restore_en(dc_restore_en));
    eqc_host_model u_eqc_host_model (.clk(clk), .miso(miso),
        .carrier_present_n(carrier_present_n), .auto_mute(auto_mute),
        .manual_squelch(man_sq), .squelch(squelch), .sck(sck), .ss_n(ss_n),
        .mosi(mosi));

    // ****************************************
    // clock, checking and bus tasks
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // reads note their expected word; the watcher below compares it
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic err);
        if (!wr)
            exp_q.push_back(d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : $urandom;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        check(pslverr, err);
        check(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    always @(posedge clk)
        if (psel && penable && pready && !pwrite)
            check(prdata, exp_q.pop_front());
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        {rst_b, psel, penable, pwrite, access_select, bypass, man_sq} = '0;
        {idle_powerdown, analog_thr_trip, serial_data_in, auto_mute} = '0;
        {paddr, pwdata} = '0;
        {energy_detect, second_output_off} = 2'b11;
        signal_metric = 8'hff;
        void'($urandom(38501));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, `EQC_OFS_CFG_BASE, 32'h0c, 1'b0);
        apb(1'b0, `EQC_OFS_INT_MASK, 32'h0, 1'b0);
        apb(1'b0, 12'h100, 32'h0, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 24; i++)
        begin
            thr = (i < 8) ? 8'h00 : 8'($urandom);
            apb(1'b1, thr_a, {24'h0, thr}, 1'b0);
            @(posedge clk);
            energy_detect <= 1'($urandom);
            analog_thr_trip <= (i % 3) == 0;
            signal_metric <= 8'($urandom);
            settle();
            e = !energy_detect | analog_thr_trip
                | (thr != 0 && signal_metric < thr);
            check(carrier_present_n, e);
        end
        $display("carrier test done");
        @(posedge clk);
        {energy_detect, analog_thr_trip, signal_metric} <= {2'b10, 8'hff};
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            {second_output_off, bypass, man_sq} <= 3'(i);
            serial_data_in <= 1'($urandom);
            settle();
            check(primary_serial_out, man_sq | serial_data_in);
            check(secondary_serial_out, man_sq | serial_data_in);
            check(secondary_out_en, !second_output_off);
            check(eq_filter_en, !bypass);
            check(dc_restore_en, !bypass);
        end
        apb(1'b0, `EQC_OFS_STATUS, 32'h18, 1'b0);
        $display("output test done");
        @(posedge clk);
        {idle_powerdown, energy_detect, man_sq, bypass} <= 4'b1000;
        settle();
        apb(1'b0, `EQC_OFS_STATUS, 32'h06, 1'b0);
        apb(1'b1, ist_a, 32'h7, 1'b0);
        apb(1'b1, `EQC_OFS_INT_MASK, 32'h1, 1'b0);
        @(posedge clk);
        {man_sq, bypass} <= 2'b11;
        settle();
        check(primary_out_en, 1'b0);
        check(eq_filter_en, 1'b0);
        check(irq, 1'b0);
        @(posedge clk);
        energy_detect <= 1'b1;
        settle();
        check(irq, 1'b1);
        check(primary_serial_out, 1'b1);
        apb(1'b0, ist_a, 32'h1, 1'b0);
        apb(1'b1, ist_a, 32'h1, 1'b0);
        @(negedge clk);
        check(irq, 1'b0);
        $display("power-down test done");
        @(posedge clk);
        {idle_powerdown, man_sq, bypass, auto_mute} <= 4'b0001;
        {energy_detect, serial_data_in} <= 2'b00;
        settle();
        check(primary_serial_out, 1'b1);
        @(posedge clk);
        energy_detect <= 1'b1;
        settle();
        check(primary_serial_out, 1'b0);
        $display("auto mute test done");
        @(posedge clk);
        {auto_mute, access_select} <= 2'b01;
        apb(1'b1, ist_a, 32'h7, 1'b0);
        u_eqc_host_model.frame(16'h0001, 16, 3, rx);
        settle();
        check(primary_serial_out, 1'b1);
        check(secondary_out_en, 1'b1);
        u_eqc_host_model.frame(16'h0380, 16, 5, rx);
        u_eqc_host_model.frame(16'h83ff, 16, 3, rx);
        u_eqc_host_model.frame(16'hffff, 16, 4, rx);
        check(rx[7:0], 8'h80);
        apb(1'b0, thr_a, 32'h80, 1'b0);
        apb(1'b0, ist_a, 32'h2, 1'b0);
        apb(1'b1, ist_a, 32'h7, 1'b0);
        u_eqc_host_model.frame(16'h0004, 8, 3, rx);
        apb(1'b0, ist_a, 32'h4, 1'b0);
        @(posedge clk);
        access_select <= 1'b0;
        u_eqc_host_model.frame(16'h000f, 16, 3, rx);
        apb(1'b0, `EQC_OFS_CFG_BASE, 32'h1, 1'b0);
        $display("serial test done");
        end_sim();
    end
endmodule

// ---- logic/eqc_cfg.svh ----
// offsets, field positions and reset values of the equalizer control block
`ifndef EQC_CFG_SVH
`define EQC_CFG_SVH

// ******************************************************
// apb register map (byte addresses)
// ******************************************************
`define EQC_APB_AW 12
`define EQC_OFS_STATUS 12'h000
`define EQC_OFS_INT_STATUS 12'h004
`define EQC_OFS_INT_MASK 12'h008
`define EQC_OFS_CFG_BASE 12'h020
`define EQC_OFS_CFG_LAST 12'h03c

// ******************************************************
// serial register file
// ******************************************************
`define EQC_NUM_CFG 8
`define EQC_CFG_IW 3
`define EQC_SPI_AW 7
`define EQC_FRAME_BITS 5'h10
`define EQC_CFG_CTRL 3'h0
`define EQC_CFG_MUTE_THR 3'h3
`define EQC_CTRL_RESET 8'h0c
`define EQC_CTRL_SQUELCH 0
`define EQC_CTRL_BYPASS 1
`define EQC_CTRL_IDLE_PD 2
`define EQC_CTRL_SEC_OFF 3

// ******************************************************
// status and interrupt bits
// ******************************************************
`define EQC_ST_SERIAL_MODE 0
`define EQC_ST_CARRIER_N 1
`define EQC_ST_POWERDOWN 2
`define EQC_ST_SQUELCHED 3
`define EQC_ST_BYPASSED 4
`define EQC_INT_W 3
`define EQC_INT_CARRIER 0
`define EQC_INT_SPI_WRITE 1
`define EQC_INT_SPI_ERR 2

`endif

// ---- logic/eqc_if.sv ----
// internal carriers: register port of the serial slave, output control
`timescale 1ns/1ps
interface eqc_reg_if;
    logic wr;
    eqc_pkg::eqc_idx_t idx;
    eqc_pkg::eqc_byte_t wdata;
    eqc_pkg::eqc_byte_t rdata;
    logic frame_err;
    modport slave (output wr, output idx, output wdata, input rdata,
        output frame_err);
    modport regs (input wr, input idx, input wdata, output rdata,
        input frame_err);
endinterface

interface eqc_ctl_if;
    logic squelch;
    logic bypass;
    logic idle_pd;
    logic no_signal;
    logic sec_off;
    logic powerdown;
    modport ctl (input squelch, input bypass, input idle_pd,
        input no_signal, input sec_off, output powerdown);
    modport top (output squelch, output bypass, output idle_pd,
        output no_signal, output sec_off, input powerdown);
endinterface

// ---- logic/eqc_out_ctrl.sv ----
// output driver control: power-down, squelch, bypass precedence
`timescale 1ns/1ps
module eqc_out_ctrl
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic data_in,
    eqc_ctl_if.ctl c,
    output logic primary_serial_out,
    output logic secondary_serial_out,
    output logic primary_out_en,
    output logic secondary_out_en,
    output logic eq_filter_en,
    output logic dc_restore_en
);
    logic pd;
    logic level;

    assign pd = c.idle_pd & c.no_signal;
    assign level = c.squelch | data_in;
    assign c.powerdown = pd;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            primary_serial_out <= 1'b1;
            secondary_serial_out <= 1'b1;
            primary_out_en <= 1'b0;
            secondary_out_en <= 1'b0;
            eq_filter_en <= 1'b0;
            dc_restore_en <= 1'b0;
        end
        else
        begin
            primary_serial_out <= level;
            secondary_serial_out <= level;
            primary_out_en <= ~pd;
            secondary_out_en <= ~pd & ~c.sec_off;
            eq_filter_en <= ~pd & ~c.bypass;
            dc_restore_en <= ~pd & ~c.bypass;
        end
    end
endmodule

// ---- logic/eqc_pkg.sv ----
// types shared by the equalizer control modules
package eqc_pkg;
    typedef logic [7:0] eqc_byte_t;
    typedef logic [2:0] eqc_idx_t;
    typedef enum logic [1:0]
    {
        EQC_SPI_IDLE = 2'b01,
        EQC_SPI_SHIFT = 2'b10
    } eqc_spi_state_e;
endpackage

// ---- logic/eqc_spi_slave.sv ----
// serial register access slave, pins sampled on the system clock
`timescale 1ns/1ps
`include "eqc_cfg.svh"
module eqc_spi_slave
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    eqc_reg_if.slave rp
);
    eqc_pkg::eqc_spi_state_e state_reg;
    logic sck_reg;
    logic ss_n_reg;
    logic [15:0] shift_reg;
    logic [4:0] count_reg;
    logic sck_rise;
    logic sck_fall;
    logic sel;
    logic frame_end;

    // idle levels: deselected and clock low
    assign sel = enable & ~ss_n;
    assign sck_rise = sck & ~sck_reg;
    assign sck_fall = ~sck & sck_reg;
    assign frame_end = (state_reg == eqc_pkg::EQC_SPI_SHIFT) & ~sel;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_reg <= 1'b0;
            ss_n_reg <= 1'b1;
        end
        else
        begin
            sck_reg <= sck;
            ss_n_reg <= ss_n;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= eqc_pkg::EQC_SPI_IDLE;
        else
        begin
            unique case (state_reg)
                eqc_pkg::EQC_SPI_IDLE:
                    if (sel)
                        state_reg <= eqc_pkg::EQC_SPI_SHIFT;
                eqc_pkg::EQC_SPI_SHIFT:
                    if (!sel)
                        state_reg <= eqc_pkg::EQC_SPI_IDLE;
            endcase
        end
    end

    // the last 16 bits of a frame count, so daisy chains pass through
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
        end
        else if (state_reg == eqc_pkg::EQC_SPI_IDLE)
            count_reg <= 5'h00;
        else if (frame_end)
        begin
            if (shift_reg[15] && count_reg >= `EQC_FRAME_BITS)
                shift_reg[7:0] <= rp.rdata;
        end
        else if (sel && sck_rise)
        begin
            shift_reg <= {shift_reg[14:0], mosi};
            if (count_reg < `EQC_FRAME_BITS)
                count_reg <= count_reg + 5'h01;
        end
    end

    // read index is taken from the frame just shifted in
    always_comb
    begin
        rp.idx = shift_reg[10:8];
        rp.wdata = shift_reg[7:0];
        rp.wr = frame_end & ~shift_reg[15] & (shift_reg[14:11] == 4'h0)
            & (count_reg >= `EQC_FRAME_BITS);
        rp.frame_err = frame_end & (count_reg < `EQC_FRAME_BITS);
    end

    // out data changes on the falling clock edge, first bit at select
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            miso <= 1'b0;
        else if ((sel && ss_n_reg) || (sel && sck_fall))
            miso <= shift_reg[15];
    end

    assign miso_oe = sel;
endmodule

// ---- logic/eqc_top.sv ----
// equalizer control logic: mode select, carrier flag, registers, apb
// Contract
// - access_select high selects serial register access, low selects pins.
// - second_output_off high floats the second driver, low enables it.
// - carrier_present_n is high with no input signal, low with signal.
// - carrier_present_n is the OR of energy-absent and threshold compare.
// - squelch high forces both serial outputs to one, low passes data.
// - bypass disables the equalizer filter and the dc restoration.
// - the mute threshold is also settable through serial register 03h.
// - serial mode reads and writes registers over mosi, miso, sck, ss.
// - an idle slave select is taken as deselected.
// - an idle serial clock is taken as low.
// - squelch takes precedence over bypass at the outputs.
// - idle power-down with no signal floats outputs over squelch, bypass.
// - a frame is 16 bits: read/write bit, seven address bits, eight data.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "eqc_cfg.svh"
module eqc_top
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic access_select,
    input wire logic second_output_off,
    input wire logic squelch,
    input wire logic bypass,
    input wire logic idle_powerdown,
    input wire logic energy_detect,
    input wire logic analog_thr_trip,
    input wire logic [7:0] signal_metric,
    input wire logic serial_data_in,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic carrier_present_n,
    output logic primary_serial_out,
    output logic secondary_serial_out,
    output logic primary_out_en,
    output logic secondary_out_en,
    output logic eq_filter_en,
    output logic dc_restore_en
);
    // ******************************************************
    // decode helpers
    // ******************************************************
    function automatic logic is_cfg(input logic [11:0] a);
        is_cfg = (a >= `EQC_OFS_CFG_BASE) && (a <= `EQC_OFS_CFG_LAST)
            && (a[1:0] == 2'b00);
    endfunction

    function automatic eqc_pkg::eqc_idx_t cfg_idx(input logic [11:0] a);
        logic [11:0] d;
        d = a - `EQC_OFS_CFG_BASE;
        cfg_idx = d[4:2];
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `EQC_OFS_STATUS) || (a == `EQC_OFS_INT_STATUS)
            || (a == `EQC_OFS_INT_MASK) || is_cfg(a);
    endfunction

    // ******************************************************
    // declarations
    // ******************************************************
    eqc_reg_if rp ();
    eqc_ctl_if cp ();
    eqc_pkg::eqc_byte_t cfg_reg [`EQC_NUM_CFG];
    logic [`EQC_INT_W-1:0] int_status_reg;
    logic [`EQC_INT_W-1:0] int_status_next;
    logic [`EQC_INT_W-1:0] int_mask_reg;
    logic [`EQC_INT_W-1:0] events;
    logic carrier_n_reg;
    logic serial_mode;
    logic thr_in_use;
    logic thr_trip;
    logic no_signal;
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    eqc_pkg::eqc_byte_t ctrl;

    // ******************************************************
    // mode and carrier flag
    // ******************************************************
    assign serial_mode = access_select;
    assign ctrl = cfg_reg[`EQC_CFG_CTRL];
    assign thr_in_use = cfg_reg[`EQC_CFG_MUTE_THR] != 8'h00;
    // a weaker metric than the programmed threshold counts as no carrier
    assign thr_trip = (thr_in_use
        && (signal_metric < cfg_reg[`EQC_CFG_MUTE_THR]))
        || analog_thr_trip;
    assign no_signal = ~energy_detect | thr_trip;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            carrier_n_reg <= 1'b1;
        else
            carrier_n_reg <= no_signal;
    end

    assign carrier_present_n = carrier_n_reg;

    // in serial mode the control register replaces the pin levels
    always_comb
    begin
        if (serial_mode)
        begin
            cp.squelch = ctrl[`EQC_CTRL_SQUELCH];
            cp.bypass = ctrl[`EQC_CTRL_BYPASS];
            cp.idle_pd = ctrl[`EQC_CTRL_IDLE_PD];
            cp.sec_off = ctrl[`EQC_CTRL_SEC_OFF];
        end
        else
        begin
            cp.squelch = squelch;
            cp.bypass = bypass;
            cp.idle_pd = idle_powerdown;
            cp.sec_off = second_output_off;
        end
        cp.no_signal = carrier_n_reg;
    end

    // ******************************************************
    // serial slave and output path
    // ******************************************************
    eqc_spi_slave u_spi
    (
        .clk(clk),
        .rst_b(rst_b),
        .enable(serial_mode),
        .sck(sck),
        .ss_n(ss_n),
        .mosi(mosi),
        .miso(miso),
        .miso_oe(miso_oe),
        .rp(rp.slave)
    );

    assign rp.rdata = cfg_reg[rp.idx];

    eqc_out_ctrl u_out
    (
        .clk(clk),
        .rst_b(rst_b),
        .data_in(serial_data_in),
        .c(cp.ctl),
        .primary_serial_out(primary_serial_out),
        .secondary_serial_out(secondary_serial_out),
        .primary_out_en(primary_out_en),
        .secondary_out_en(secondary_out_en),
        .eq_filter_en(eq_filter_en),
        .dc_restore_en(dc_restore_en)
    );

    // ******************************************************
    // apb slave
    // ******************************************************
    // zero wait states; unmapped offsets answer with an error
    assign apb_access = psel & penable;
    assign apb_wr = apb_access & pwrite & mapped(paddr);
    assign apb_rd = apb_access & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = apb_access & ~mapped(paddr);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h00000000;
            if (paddr == `EQC_OFS_STATUS)
            begin
                prdata[`EQC_ST_SERIAL_MODE] <= serial_mode;
                prdata[`EQC_ST_CARRIER_N] <= carrier_n_reg;
                prdata[`EQC_ST_POWERDOWN] <= cp.powerdown;
                prdata[`EQC_ST_SQUELCHED] <= cp.squelch;
                prdata[`EQC_ST_BYPASSED] <= cp.bypass;
            end
            else if (paddr == `EQC_OFS_INT_STATUS)
                prdata[`EQC_INT_W-1:0] <= int_status_reg;
            else if (paddr == `EQC_OFS_INT_MASK)
                prdata[`EQC_INT_W-1:0] <= int_mask_reg;
            else if (is_cfg(paddr))
                prdata[7:0] <= cfg_reg[cfg_idx(paddr)];
        end
    end

    // ******************************************************
    // serial register file
    // ******************************************************
    // a serial write in the same cycle as an apb write wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `EQC_NUM_CFG; i++)
                cfg_reg[i] <= 8'h00;
            cfg_reg[`EQC_CFG_CTRL] <= `EQC_CTRL_RESET;
        end
        else if (rp.wr)
            cfg_reg[rp.idx] <= rp.wdata;
        else if (apb_wr && is_cfg(paddr))
            cfg_reg[cfg_idx(paddr)] <= pwdata[7:0];
    end

    // ******************************************************
    // interrupts
    // ******************************************************
    assign events[`EQC_INT_CARRIER] = carrier_n_reg ^ no_signal;
    assign events[`EQC_INT_SPI_WRITE] = rp.wr;
    assign events[`EQC_INT_SPI_ERR] = rp.frame_err;

    // a new event beats a write-one-to-clear in the same cycle
    always_comb
    begin
        int_status_next = int_status_reg;
        if (apb_wr && paddr == `EQC_OFS_INT_STATUS)
            int_status_next = int_status_reg & ~pwdata[`EQC_INT_W-1:0];
        int_status_next = int_status_next | events;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            int_status_reg <= 3'h0;
        else
            int_status_reg <= int_status_next;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            int_mask_reg <= 3'h0;
        else if (apb_wr && paddr == `EQC_OFS_INT_MASK)
            int_mask_reg <= pwdata[`EQC_INT_W-1:0];
    end

    assign irq = |(int_status_reg & int_mask_reg);
endmodule
